/* pkg/bsi_map.vh */
// constants shared by the burst sram interface design files
`ifndef BSI_MAP_VH
`define BSI_MAP_VH

// organisation: 2 byte lanes gives the 18-bit part, 4 gives the 36-bit part
`define BSI_BYTES       2
`define BSI_BYTE_W      9
`define BSI_ADDR_W      20

// burst of two words: second word address is base plus this step
`define BSI_BURST_STEP  1

// posted write buffer depth in whole bursts
`define BSI_BUF_DEPTH   2

// command encodings as seen on load_strobe_n and rw_select
`define BSI_LOAD_ACTIVE 1'b0
`define BSI_RW_READ     1'b1
`define BSI_RW_WRITE    1'b0

`endif

/* hdl/bsi_burst_buffer.v */
// two-entry buffer holding posted write bursts, both entries visible for bypass
`timescale 1ns/100ps
`include "bsi_map.vh"

module bsi_burst_buffer #(
	parameter W = 8
) (
	input  wire         clk_in,
	input  wire         rst_in,
	input  wire         push_valid_in,
	output wire         push_ready_out,
	input  wire [W-1:0] push_data_in,
	output wire         pop_valid_out,
	input  wire         pop_ready_in,
	output wire [W-1:0] head_data_out,
	output wire         second_valid_out,
	output wire [W-1:0] second_data_out
);

	// =====================================================================
	// storage: entry 0 is always the oldest
	reg [W-1:0] entry0;
	reg [W-1:0] entry1;
	reg [1:0]   count;

	wire do_pop  = pop_ready_in && (count != 2'h0);
	wire do_push = push_valid_in && push_ready_out;

	// a pop in the same cycle frees a slot, so a full buffer still accepts
	assign push_ready_out   = (count != `BSI_BUF_DEPTH) || pop_ready_in;
	assign pop_valid_out    = (count != 2'h0);
	assign head_data_out    = entry0;
	assign second_valid_out = (count == `BSI_BUF_DEPTH);
	assign second_data_out  = entry1;

	always @(posedge clk_in) begin
		if (rst_in) begin
			count  <= 2'h0;
			entry0 <= {W{1'b0}};
			entry1 <= {W{1'b0}};
		end else begin
			case ({do_push, do_pop})
				2'b10: begin
					if (count == 2'h0)
						entry0 <= push_data_in;
					else
						entry1 <= push_data_in;
					count <= count + 2'h1;
				end
				2'b01: begin
					entry0 <= entry1;
					count  <= count - 2'h1;
				end
				2'b11: begin
					if (count == 2'h1)
						entry0 <= push_data_in;
					else begin
						entry0 <= entry1;
						entry1 <= push_data_in;
					end
				end
				default: begin
					count <= count;
				end
			endcase
		end
	end

endmodule // bsi_burst_buffer

/* hdl/bsi_burst_sram_if.v */
// two-word burst double-data-rate sram: command decode, posted writes, read pipeline
`timescale 1ns/100ps
`include "bsi_map.vh"

module bsi_burst_sram_if #(
	parameter AW = `BSI_ADDR_W,
	parameter BN = `BSI_BYTES
) (
	input  wire                        clk_in,
	input  wire                        rst_in,
	input  wire                        load_strobe_n_in,
	input  wire                        rw_select_in,
	input  wire [AW-1:0]               addr_in,
	input  wire [BN*`BSI_BYTE_W-1:0]   dq_rise_in,
	input  wire [BN*`BSI_BYTE_W-1:0]   dq_fall_in,
	input  wire [BN-1:0]               byte_write_select_n_rise_in,
	input  wire [BN-1:0]               byte_write_select_n_fall_in,
	output reg  [BN*`BSI_BYTE_W-1:0]   dq_fall_out,
	output reg                         dq_fall_oe_out,
	output reg  [BN*`BSI_BYTE_W-1:0]   dq_rise_out,
	output reg                         dq_rise_oe_out,
	output reg                         write_ready_out
);

	localparam DW    = BN * `BSI_BYTE_W;
	localparam BW    = `BSI_BYTE_W;
	localparam D0_LO = 0;
	localparam D1_LO = DW;
	localparam E0_LO = 2 * DW;
	localparam E1_LO = 2 * DW + BN;
	localparam A_LO  = 2 * DW + 2 * BN;
	localparam EW    = A_LO + AW;
	localparam [AW-1:0] STEP = `BSI_BURST_STEP;

	// =====================================================================
	// array
	// not reset: contents after power-up are undefined, as on the real part
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// =====================================================================
	// command stage
	// a command is taken only on an edge with the load strobe low; read-write
	// select is a don't-care otherwise, so a deselected bus costs nothing
	reg          wr_pend;
	reg [AW-1:0] wr_addr;
	reg          rd_pend;
	reg [AW-1:0] rd_addr;

	wire take_cmd = (load_strobe_n_in == `BSI_LOAD_ACTIVE);
	wire wr_cmd   = take_cmd && (rw_select_in == `BSI_RW_WRITE);
	wire rd_cmd   = take_cmd && (rw_select_in == `BSI_RW_READ);

	// =====================================================================
	// posted write buffer
	// write data arrives one edge after its command, so the burst is pushed from
	// wr_pend; the array is only touched by the commit of an older burst, which
	// keeps the read path of the same cycle free of any write conflict
	wire          buf_push_ready;
	wire          buf_head_valid;
	wire [EW-1:0] buf_head;
	wire          buf_second_valid;
	wire [EW-1:0] buf_second;
	wire [EW-1:0] push_entry;
	wire          commit = wr_cmd && buf_head_valid;

	// enables are the inverted active-low selects, one set per word
	assign push_entry = {wr_addr, ~byte_write_select_n_fall_in, ~byte_write_select_n_rise_in,
		dq_fall_in, dq_rise_in};

	bsi_burst_buffer #(
		.W (EW)
	) u_buf (
		.clk_in           (clk_in),
		.rst_in           (rst_in),
		.push_valid_in    (wr_pend),
		.push_ready_out   (buf_push_ready),
		.push_data_in     (push_entry),
		.pop_valid_out    (buf_head_valid),
		.pop_ready_in     (commit),
		.head_data_out    (buf_head),
		.second_valid_out (buf_second_valid),
		.second_data_out  (buf_second)
	);

	// =====================================================================
	// byte-lane merge shared by array commit and read bypass
	function [DW-1:0] lane_merge;
		input [DW-1:0] old_word;
		input [DW-1:0] new_word;
		input [BN-1:0] en;
		integer        i;
		begin
			lane_merge = old_word;
			for (i = 0; i < BN; i = i + 1) begin
				if (en[i])
					lane_merge[i*BW +: BW] = new_word[i*BW +: BW];
			end
		end
	endfunction

	// overlay one buffered burst onto a word read for address a
	function [DW-1:0] entry_overlay;
		input [DW-1:0] word;
		input [EW-1:0] e;
		input [AW-1:0] a;
		reg   [AW-1:0] base;
		begin
			base          = e[A_LO +: AW];
			entry_overlay = word;
			if (base == a)
				entry_overlay = lane_merge(entry_overlay, e[D0_LO +: DW], e[E0_LO +: BN]);
			if (base + STEP == a)
				entry_overlay = lane_merge(entry_overlay, e[D1_LO +: DW], e[E1_LO +: BN]);
		end
	endfunction

	// newest data for address a: array, then oldest buffered burst, then newer
	function [DW-1:0] read_word;
		input [AW-1:0] a;
		begin
			read_word = mem[a];
			if (buf_head_valid)
				read_word = entry_overlay(read_word, buf_head, a);
			if (buf_second_valid)
				read_word = entry_overlay(read_word, buf_second, a);
		end
	endfunction

	// =====================================================================
	// read pipeline
	// the falling-edge word of cycle t+2 is a register loaded at edge t+2;
	// the rising-edge word follows one edge later out of rise_hold
	reg          rd_valid;
	reg [DW-1:0] rd_word0;
	reg [DW-1:0] rd_word1;
	reg          rise_hold_valid;
	reg [DW-1:0] rise_hold;
	wire [AW-1:0] rd_addr_next = rd_addr + STEP;

	// every stage is a plain register, so a stopped clock freezes the pins as they are
	always @(posedge clk_in) begin
		if (rst_in) begin
			wr_pend         <= 1'b0;
			wr_addr         <= {AW{1'b0}};
			rd_pend         <= 1'b0;
			rd_addr         <= {AW{1'b0}};
			rd_valid        <= 1'b0;
			rd_word0        <= {DW{1'b0}};
			rd_word1        <= {DW{1'b0}};
			rise_hold_valid <= 1'b0;
			rise_hold       <= {DW{1'b0}};
			dq_fall_out     <= {DW{1'b0}};
			dq_fall_oe_out  <= 1'b0;
			dq_rise_out     <= {DW{1'b0}};
			dq_rise_oe_out  <= 1'b0;
			write_ready_out <= 1'b0;
		end else begin
			// edge t: latch base address of the new burst
			wr_pend <= wr_cmd;
			if (wr_cmd)
				wr_addr <= addr_in;
			rd_pend <= rd_cmd;
			if (rd_cmd)
				rd_addr <= addr_in;
			// edge t+1: fetch both words with bypass
			rd_valid <= rd_pend;
			if (rd_pend) begin
				rd_word0 <= read_word(rd_addr);
				rd_word1 <= read_word(rd_addr_next);
			end
			// edge t+2: word A on the falling-edge lane, A+1 held a cycle
			dq_fall_oe_out  <= rd_valid;
			if (rd_valid)
				dq_fall_out <= rd_word0;
			rise_hold_valid <= rd_valid;
			if (rd_valid)
				rise_hold <= rd_word1;
			// edge t+3: word A+1 on the rising-edge lane
			dq_rise_oe_out <= rise_hold_valid;
			if (rise_hold_valid)
				dq_rise_out <= rise_hold;
			// low only if a posted burst found no free slot; the commit taken on
			// every write command keeps that from happening in legal use
			write_ready_out <= buf_push_ready || !wr_pend;
		end
	end

	// =====================================================================
	// array commit: the oldest posted burst is written when the next write arrives
	// both words of one burst go in together; a lane with its enable low keeps
	// the stored bits, and a word with all enables low leaves that address alone
	always @(posedge clk_in) begin
		if (commit) begin
			// all enables low leaves the stored word as it was
			mem[buf_head[A_LO +: AW]] <= lane_merge(mem[buf_head[A_LO +: AW]],
				buf_head[D0_LO +: DW], buf_head[E0_LO +: BN]);
			mem[buf_head[A_LO +: AW] + STEP] <= lane_merge(mem[buf_head[A_LO +: AW] + STEP],
				buf_head[D1_LO +: DW], buf_head[E1_LO +: BN]);
		end
	end

endmodule // bsi_burst_sram_if

/* sim/bsi_sram_checker.sv */
// concurrent checks on the burst sram interface ports
`timescale 1ns/100ps
`include "bsi_map.vh"

module bsi_sram_checker #(
	parameter AW = 6,
	parameter BN = 2
) (
	input wire                      clk_in,
	input wire                      rst_in,
	input wire                      load_strobe_n_in,
	input wire                      rw_select_in,
	input wire [BN*`BSI_BYTE_W-1:0] dq_fall_out,
	input wire                      dq_fall_oe_out,
	input wire                      dq_rise_oe_out,
	input wire                      write_ready_out
);
	// ==========================================
	// timing of the read pipeline, write ready after reset and outputs during reset
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	rd_fall_lat_a: assert property ((!load_strobe_n_in && rw_select_in) |-> ##3 dq_fall_oe_out)
		else $error("first read word not driven on time");
	rd_rise_lat_a: assert property ((!load_strobe_n_in && rw_select_in) |-> ##4 dq_rise_oe_out)
		else $error("second read word not driven on time");
	fall_cause_a: assert property (
		dq_fall_oe_out |-> !$past(load_strobe_n_in, 3) && $past(rw_select_in, 3))
		else $error("read word driven without a read command");
	rise_follow_a: assert property (dq_rise_oe_out |-> $past(dq_fall_oe_out))
		else $error("second word without a first word");
	idle_quiet_a: assert property (load_strobe_n_in [*4] |=> !dq_fall_oe_out && !dq_rise_oe_out)
		else $error("outputs driven while deselected");
	write_silent_a: assert property (
		(!load_strobe_n_in && !rw_select_in) |-> ##3 !dq_fall_oe_out ##1 !dq_rise_oe_out)
		else $error("write produced read data");
	hold_last_a: assert property ($fell(dq_fall_oe_out) |-> $stable(dq_fall_out))
		else $error("data changed when output released");
	ready_up_a: assert property ($fell(rst_in) |=> write_ready_out)
		else $error("buffer not ready after reset");
	reset_quiet_a: assert property (disable iff (1'b0) rst_in |=> !dq_fall_oe_out && !dq_rise_oe_out)
		else $error("outputs driven during reset");
endmodule // bsi_sram_checker

bind bsi_burst_sram_if bsi_sram_checker #(.AW(AW), .BN(BN)) bsi_sram_checker_inst (
	.clk_in(clk_in), .rst_in(rst_in), .load_strobe_n_in(load_strobe_n_in), .rw_select_in(rw_select_in),
	.dq_fall_out(dq_fall_out), .dq_fall_oe_out(dq_fall_oe_out), .dq_rise_oe_out(dq_rise_oe_out),
	.write_ready_out(write_ready_out));

/* sim/bsi_ctrl_model.sv */
// random memory controller driving commands, write data and lane selects
`timescale 1ns/100ps

module bsi_ctrl_model (
	input  wire        clk_in,
	input  wire        rst_in,
	output reg         load_strobe_n_out,
	output reg         rw_select_out,
	output reg  [5:0]  addr_out,
	output reg  [17:0] dq_rise_out,
	output reg  [17:0] dq_fall_out,
	output reg  [1:0]  byte_write_select_n_rise_out,
	output reg  [1:0]  byte_write_select_n_fall_out
);
	// ==========================================
	// command stream
	integer seed = 32'h1A97;
	integer r, d1, d2;
	integer gap = 9;
	initial begin
		load_strobe_n_out = 1'b1;
		rw_select_out = 1'b0;
		addr_out = 6'h00;
		dq_rise_out = 18'h00000;
		dq_fall_out = 18'h00000;
		byte_write_select_n_rise_out = 2'h0;
		byte_write_select_n_fall_out = 2'h0;
	end
	// narrow address range so reads often hit posted data
	always @(posedge clk_in) begin
		r = $random(seed);
		d1 = $random(seed);
		d2 = $random(seed);
		dq_rise_out <= d1[17:0];
		dq_fall_out <= d2[17:0];
		byte_write_select_n_rise_out <= r[9:8];
		byte_write_select_n_fall_out <= r[11:10];
		addr_out <= {3'h0, r[6:4]};
		gap = gap + 1;
		load_strobe_n_out <= 1'b1;
		if (!rst_in && r[1:0] != 2'h0) begin
			if (r[2]) begin
				load_strobe_n_out <= 1'b0;
				rw_select_out <= 1'b1;
				gap = 0;
			end else if (gap >= 3) begin
				load_strobe_n_out <= 1'b0;
				rw_select_out <= 1'b0;
			end
		end
	end
endmodule // bsi_ctrl_model

/* sim/bsi_burst_sram_if_test.sv */
// self-checking bench: scoreboard model of the burst sram against the design
`timescale 1ns/100ps
`include "bsi_map.vh"

module bsi_burst_sram_if_test;
	reg          clk_in = 1'b0;
	reg          rst_in = 1'b1;
	reg          rst_q = 1'b1;
	wire         ld_n, rw, foe, roe, rdy;
	wire [5:0]   addr;
	wire [17:0]  dr, df, qf, qr;
	wire [1:0]   br, bf;
	integer      fail_count = 0, n_compared = 0, cyc = 0, s, i;
	reg  [17:0]  mem [0:63];
	reg  [17:0]  ef_d [0:7], er_d [0:7];
	reg          ef_v [0:7], er_v [0:7];
	reg  [35:0]  mem4 [0:63];
	reg  [35:0]  ef4_d [0:7], er4_d [0:7];
	wire         foe4, roe4, rdy4;
	wire [35:0]  qf4, qr4;
	// the wide organisation gets both random words packed across its four lanes
	wire [35:0]  dr4 = {df, dr};
	wire [35:0]  df4 = {dr, df};
	wire [3:0]   sr4 = {bf, br};
	wire [3:0]   sf4 = {br, bf};
	reg          wp = 1'b0;
	reg  [5:0]   wa;
	bsi_ctrl_model bsi_ctrl_model_inst (.clk_in(clk_in), .rst_in(rst_in), .load_strobe_n_out(ld_n),
		.rw_select_out(rw), .addr_out(addr), .dq_rise_out(dr), .dq_fall_out(df), .byte_write_select_n_rise_out(br),
		.byte_write_select_n_fall_out(bf));
	bsi_burst_sram_if #(.AW(6), .BN(2)) bsi_burst_sram_if_inst (.clk_in(clk_in), .rst_in(rst_in),
		.load_strobe_n_in(ld_n), .rw_select_in(rw), .addr_in(addr), .dq_rise_in(dr), .dq_fall_in(df),
		.byte_write_select_n_rise_in(br), .byte_write_select_n_fall_in(bf), .dq_fall_out(qf),
		.dq_fall_oe_out(foe), .dq_rise_out(qr), .dq_rise_oe_out(roe), .write_ready_out(rdy));
	bsi_burst_sram_if #(.AW(6), .BN(4)) bsi_burst_sram_if_wide_inst (.clk_in(clk_in), .rst_in(rst_in),
		.load_strobe_n_in(ld_n), .rw_select_in(rw), .addr_in(addr), .dq_rise_in(dr4), .dq_fall_in(df4),
		.byte_write_select_n_rise_in(sr4), .byte_write_select_n_fall_in(sf4), .dq_fall_out(qf4),
		.dq_fall_oe_out(foe4), .dq_rise_out(qr4), .dq_rise_oe_out(roe4), .write_ready_out(rdy4));
	// ==========================================
	// checking and closing
	task chk_bit(input b, input e, input string m);
		n_compared = n_compared + 1;
		if (b !== e) begin
			fail_count = fail_count + 1;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task chk_word(input [35:0] v, input [35:0] e, input string m);
		n_compared = n_compared + 1;
		if (v !== e) begin
			fail_count = fail_count + 1;
			$display("[ERR] %0t %s got %h want %h", $time, m, v, e);
		end
	endtask
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always #12.5 clk_in = ~clk_in;
	initial begin
		for (i = 0; i < 8; i = i + 1) begin
			ef_v[i] = 1'b0;
			er_v[i] = 1'b0;
		end
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (2000) @(posedge clk_in);
		report_and_stop;
	end
	initial begin
		#(3000 * 25);
		fail_count = fail_count + 1;
		report_and_stop;
	end
	// ==========================================
	// reference model: posted data is visible at once, so writes land straight in mem
	always @(posedge clk_in) begin
		cyc = cyc + 1;
		rst_q = rst_in;
		if (rst_in) begin
			wp = 1'b0;
		end else begin
			if (wp) begin
				for (i = 0; i < 2; i = i + 1) begin
					if (!br[i]) mem[wa][9*i +: 9] = dr[9*i +: 9];
					if (!bf[i]) mem[(wa + 6'h01) % 64][9*i +: 9] = df[9*i +: 9];
				end
				for (i = 0; i < 4; i = i + 1) begin
					if (!sr4[i]) mem4[wa][9*i +: 9] = dr4[9*i +: 9];
					if (!sf4[i]) mem4[(wa + 6'h01) % 64][9*i +: 9] = df4[9*i +: 9];
				end
			end
			wp = !ld_n && !rw;
			wa = addr;
			if (!ld_n && rw) begin
				ef_v[(cyc + 2) % 8] = 1'b1;
				ef_d[(cyc + 2) % 8] = mem[addr];
				er_v[(cyc + 3) % 8] = 1'b1;
				er_d[(cyc + 3) % 8] = mem[(addr + 6'h01) % 64];
				ef4_d[(cyc + 2) % 8] = mem4[addr];
				er4_d[(cyc + 3) % 8] = mem4[(addr + 6'h01) % 64];
			end
		end
	end
	always @(negedge clk_in) begin
		if (!rst_q) begin
			s = cyc % 8;
			chk_bit(foe, ef_v[s], "first word enable");
			if (ef_v[s]) chk_word(qf, ef_d[s], "first word");
			chk_bit(roe, er_v[s], "second word enable");
			if (er_v[s]) chk_word(qr, er_d[s], "second word");
			chk_bit(rdy, 1'b1, "buffer ready");
			chk_bit(foe4, ef_v[s], "wide first word enable");
			if (ef_v[s]) chk_word(qf4, ef4_d[s], "wide first word");
			chk_bit(roe4, er_v[s], "wide second word enable");
			if (er_v[s]) chk_word(qr4, er4_d[s], "wide second word");
			chk_bit(rdy4, 1'b1, "wide buffer ready");
			ef_v[s] = 1'b0;
			er_v[s] = 1'b0;
		end
	end
endmodule // bsi_burst_sram_if_test
